// ===== rtl/cams_pkg.sv
/*
 * Constants and carrier types for the core arithmetic datapath.
 * Assumes a single core clock and a synchronous active-low reset.
 */
package cams_pkg;

    // Register map of the plain register port
    localparam logic [3:0] CAMS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] CAMS_ADDR_STAT = 4'h1;
    localparam logic [3:0] CAMS_ADDR_DSTAT = 4'h2;

    // Control word field positions and reset value
    localparam int CAMS_CTRL_TOP_BIT = 3;
    localparam int CAMS_CTRL_RSVD_BIT = 2;
    localparam logic CAMS_TOP_RST = 1'h0;

    // Status word field positions
    localparam int CAMS_SR_C = 0;
    localparam int CAMS_SR_Z = 1;
    localparam int CAMS_SR_OV = 2;
    localparam int CAMS_SR_N = 3;
    localparam int CAMS_SR_IPL_LO = 5;
    localparam int CAMS_SR_DC = 8;
    localparam logic [15:0] CAMS_SR_RST = 16'h0000;

    // Divide timing: one setup cycle, 16 iterations, fix-up and write-back
    localparam logic [4:0] CAMS_DIV_CYCLES = 5'h13;
    localparam logic [4:0] CAMS_DIV_ITERS = 5'h10;

    // ALU operation codes
    typedef enum logic [3:0] {
        OP_ADD = 4'b0000,
        OP_SUB = 4'b0001,
        OP_AND = 4'b0010,
        OP_IOR = 4'b0011,
        OP_XOR = 4'b0100,
        OP_ASR = 4'b0101,
        OP_SL = 4'b0110,
        OP_LSR = 4'b0111,
        OP_MUL = 4'b1000,
        OP_DIV = 4'b1001,
        OP_NOP = 4'b1111
    } cams_op_t;

    // Multiplier operand forms
    typedef enum logic [2:0] {
        MUL_SS = 3'b000,
        MUL_UU = 3'b001,
        MUL_US = 3'b010,
        MUL_SLIT = 3'b011,
        MUL_ULIT = 3'b100,
        MUL_BB = 3'b101
    } cams_mul_t;

    // Divider states
    typedef enum logic [1:0] {
        DV_IDLE = 2'b00,
        DV_ITER = 2'b01,
        DV_FIX = 2'b10,
        DV_DONE = 2'b11
    } cams_dvst_t;

    // One issued operation from the decoder
    typedef struct packed {
        logic valid;
        cams_op_t op;
        logic byte_mode;
        logic src_mem;
        logic dst_mem;
        cams_mul_t mul_mode;
        logic div_signed;
        logic div_long;
        logic [3:0] shamt;
        logic [4:0] lit;
        logic [15:0] opa;
        logic [15:0] opb;
        logic [15:0] mem_a;
        logic [15:0] div_hi;
        logic [3:0] dst_idx;
    } cams_req_t;

    // One result write
    typedef struct packed {
        logic wr_reg;
        logic wr_mem;
        logic wr_pair;
        logic [3:0] idx;
        logic [15:0] lo;
        logic [15:0] hi;
    } cams_res_t;

    // Whole module state
    typedef struct packed {
        logic [15:0] sr;
        logic top_bit;
        cams_res_t res;
        cams_dvst_t dv_st;
        logic [4:0] dv_cnt;
        logic [31:0] dv_rem_q;
        logic [15:0] dv_den;
        logic dv_sgn;
        logic dv_nq;
        logic dv_nr;
        logic busy;
        logic [15:0] rdata;
    } cams_state_t;

endpackage

// ===== rtl/cams_datapath.sv
/*
 * Core arithmetic datapath: ALU with flags, multiplier, iterative divider,
 * barrel shifter and the core control word.
 * Assumes the decoder presents operands already read from the working
 * registers or data memory and holds off new ops while busy is high.
 */
`timescale 1ns/10ps

// Summary of operation
// - 16-bit ALU doing add, subtract, shifts, logic in two's complement.
// - ALU updates carry, zero, negative, overflow and half carry in status word.
// - On subtraction carry and half carry are set when no borrow occurred.
// - Operand width is byte or word per instruction mode.
// - Sources from registers or memory; result to registers or memory.
// - Multiplier has two 17-bit inputs for signed, unsigned, mixed products.
// - Forms: SxS, UxU, UxS, 16-bit times 5-bit literal, 8x8 unsigned.
// - Divide 32/16 and 16/16, signed and unsigned.
// - Quotient goes to register zero, remainder to register one.
// - Divisor from any register; dividend from even/odd pair, odd upper.
// - One iteration per divisor bit, same time for both dividend sizes.
// - Divide takes 19 cycles and may be abandoned at any cycle boundary.
// - Single-cycle arithmetic right or left shift up to 15 places.
// - Multibit shifts read and write working registers only.
// - Shift set: arithmetic right, left and logical right.
// - Control bit 3 is priority top bit: reset 0, clear-only, set above 7.
// - Priority level is top bit above status bits 7 to 5.
// - Control bit 2 reads one; bits other than 3 and 2 read zero.
// - Overflow set on signed overflow, cleared on add or subtract without it; logic ops and shifts keep it.
module cams_datapath
    import cams_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Operation from the decoder
    input wire cams_req_t req,
    input wire logic div_abort,
    input wire logic ipl_raise,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    // Results
    output cams_res_t res,
    output logic busy,
    output logic [15:0] alu_status_word,
    output logic [3:0] cpu_priority,
    output logic [15:0] reg_rdata
);

    cams_state_t s_r;
    cams_state_t s_nxt;

    // Combinational ALU and shifter results
    logic [16:0] sum;
    logic [4:0] nib;
    logic [8:0] bsum;
    logic [15:0] b_eff;
    logic [15:0] r;
    logic cy;
    logic dc;
    logic ov;
    logic arith;
    logic [16:0] ma;
    logic [16:0] mb;
    logic [33:0] prod;
    logic [16:0] trial;
    logic [31:0] dvd;
    logic [15:0] den;

    always_comb begin
        // Subtract is add of the inverted operand plus one, so carry means no borrow
        b_eff = (req.op == OP_SUB) ? ~req.opb : req.opb;
        sum = {1'b0, req.opa} + {1'b0, b_eff} + {16'h0000, (req.op == OP_SUB)};
        nib = {1'b0, req.opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, (req.op == OP_SUB)};
        bsum = {1'b0, req.opa[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, (req.op == OP_SUB)};
        arith = (req.op == OP_ADD) || (req.op == OP_SUB);
        r = 16'h0000;
        case (req.op)
            OP_ADD, OP_SUB: r = sum[15:0];
            OP_AND: r = req.opa & req.opb;
            OP_IOR: r = req.opa | req.opb;
            OP_XOR: r = req.opa ^ req.opb;
            OP_ASR: r = 16'($signed(req.opa) >>> req.shamt);
            OP_SL: r = req.opa << req.shamt;
            OP_LSR: r = req.opa >> req.shamt;
            default: r = 16'h0000;
        endcase
        // Byte mode: flags from low byte, half carry from bit 3
        if (req.byte_mode) begin
            cy = bsum[8];
            dc = nib[4];
            ov = (req.opa[7] == b_eff[7]) && (bsum[7] != req.opa[7]);
        end else begin
            cy = sum[16];
            dc = bsum[8];
            ov = (req.opa[15] == b_eff[15]) && (sum[15] != req.opa[15]);
        end
    end

    // Multiplier operand extension by form
    always_comb begin
        ma = {1'b0, req.opa};
        mb = {1'b0, req.opb};
        case (req.mul_mode)
            MUL_SS: begin
                ma = {req.opa[15], req.opa};
                mb = {req.opb[15], req.opb};
            end
            MUL_UU: ;
            MUL_US: mb = {req.opb[15], req.opb};
            MUL_SLIT: begin
                ma = {req.opa[15], req.opa};
                mb = {12'h000, req.lit};
            end
            MUL_ULIT: mb = {12'h000, req.lit};
            MUL_BB: begin
                ma = {9'h000, req.opa[7:0]};
                mb = {9'h000, req.opb[7:0]};
            end
            default: ;
        endcase
        prod = $signed(ma) * $signed(mb);
    end

    // Restoring step on the partial remainder in the upper half
    assign trial = {s_r.dv_rem_q[31:15]} - {1'b0, s_r.dv_den};

    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.res.wr_reg = 1'b0;
        s_nxt.res.wr_mem = 1'b0;
        s_nxt.res.wr_pair = 1'b0;
        s_nxt.rdata = 16'h0000;
        // Dividend pair: odd register is upper half
        dvd = req.div_long ? {req.div_hi, req.opa} :
            (req.div_signed ? {{16{req.opa[15]}}, req.opa} : {16'h0000, req.opa});
        den = req.opb;
        // Top bit follows a hardware raise; software may only clear it
        if (reg_wr && reg_addr == CAMS_ADDR_CTRL && !reg_wdata[CAMS_CTRL_TOP_BIT]) begin
            s_nxt.top_bit = 1'b0;
        end
        if (ipl_raise) begin
            s_nxt.top_bit = 1'b1;
        end
        if (reg_wr && reg_addr == CAMS_ADDR_STAT) begin
            s_nxt.sr = reg_wdata & 16'h01EF;
        end
        if (reg_rd) begin
            case (reg_addr)
                CAMS_ADDR_CTRL: begin
                    s_nxt.rdata[CAMS_CTRL_TOP_BIT] = s_r.top_bit;
                    s_nxt.rdata[CAMS_CTRL_RSVD_BIT] = 1'b1;
                end
                CAMS_ADDR_STAT: s_nxt.rdata = s_r.sr;
                CAMS_ADDR_DSTAT: s_nxt.rdata = {11'h000, s_r.dv_cnt};
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
        // Issue of a single-cycle op
        if (req.valid && !s_r.busy && req.op != OP_DIV && req.op != OP_NOP) begin
            s_nxt.res.idx = req.dst_idx;
            s_nxt.res.hi = 16'h0000;
            if (req.op == OP_MUL) begin
                s_nxt.res.wr_reg = 1'b1;
                s_nxt.res.wr_pair = 1'b1;
                s_nxt.res.lo = prod[15:0];
                s_nxt.res.hi = prod[31:16];
            end else begin
                // Shifts never target memory
                s_nxt.res.wr_mem = req.dst_mem && req.op < OP_ASR;
                s_nxt.res.wr_reg = !(req.dst_mem && req.op < OP_ASR);
                s_nxt.res.lo = req.byte_mode ? {req.mem_a[15:8], r[7:0]} : r;
                s_nxt.sr[CAMS_SR_Z] = req.byte_mode ? (r[7:0] == 8'h00) : (r == 16'h0000);
                s_nxt.sr[CAMS_SR_N] = req.byte_mode ? r[7] : r[15];
                if (arith) begin
                    s_nxt.sr[CAMS_SR_C] = cy;
                    s_nxt.sr[CAMS_SR_DC] = dc;
                    s_nxt.sr[CAMS_SR_OV] = ov;
                end
            end
        end
        // Divider sequencer
        case (s_r.dv_st)
            DV_IDLE: begin
                if (req.valid && !s_r.busy && req.op == OP_DIV) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.dv_cnt = 5'h01;
                    s_nxt.dv_st = DV_ITER;
                    s_nxt.dv_sgn = req.div_signed;
                    // Signed divides run on magnitudes; signs come back in the fix-up
                    s_nxt.dv_nq = req.div_signed && (dvd[31] ^ den[15]);
                    s_nxt.dv_nr = req.div_signed && dvd[31];
                    s_nxt.dv_rem_q = (req.div_signed && dvd[31]) ? 32'h0 - dvd : dvd;
                    s_nxt.dv_den = (req.div_signed && den[15]) ? 16'h0 - den : den;
                end
            end
            DV_ITER: begin
                // One step per divisor bit regardless of dividend size
                s_nxt.dv_cnt = s_r.dv_cnt + 5'h01;
                if (!trial[16]) begin
                    s_nxt.dv_rem_q = {trial[15:0], s_r.dv_rem_q[14:0], 1'b1};
                end else begin
                    s_nxt.dv_rem_q = {s_r.dv_rem_q[30:0], 1'b0};
                end
                if (s_r.dv_cnt == CAMS_DIV_ITERS) s_nxt.dv_st = DV_FIX;
            end
            DV_FIX: begin
                s_nxt.dv_cnt = s_r.dv_cnt + 5'h01;
                if (s_r.dv_nq) s_nxt.dv_rem_q[15:0] = 16'h0 - s_r.dv_rem_q[15:0];
                if (s_r.dv_nr) s_nxt.dv_rem_q[31:16] = 16'h0 - s_r.dv_rem_q[31:16];
                s_nxt.dv_st = DV_DONE;
            end
            DV_DONE: begin
                // Write quotient to register zero and remainder to register one
                s_nxt.dv_cnt = s_r.dv_cnt + 5'h01;
                s_nxt.res.wr_reg = 1'b1;
                s_nxt.res.wr_pair = 1'b1;
                s_nxt.res.idx = 4'h0;
                s_nxt.res.lo = s_r.dv_rem_q[15:0];
                s_nxt.res.hi = s_r.dv_rem_q[31:16];
                // An abort in this cycle leaves the flags as they were
                if (!div_abort) begin
                    s_nxt.sr[CAMS_SR_Z] = (s_r.dv_rem_q[15:0] == 16'h0000);
                    s_nxt.sr[CAMS_SR_N] = s_r.dv_rem_q[15];
                end
                s_nxt.busy = 1'b0;
                s_nxt.dv_st = DV_IDLE;
            end
            default: s_nxt.dv_st = DV_IDLE;
        endcase
        // Abort at any cycle boundary drops the divide without a write
        if (div_abort && s_r.dv_st != DV_IDLE) begin
            s_nxt.dv_st = DV_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.res.wr_reg = 1'b0;
            s_nxt.res.wr_pair = 1'b0;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.sr <= CAMS_SR_RST;
            s_r.top_bit <= CAMS_TOP_RST;
            s_r.dv_st <= DV_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs all come from the state register
    assign res = s_r.res;
    assign busy = s_r.busy;
    assign alu_status_word = s_r.sr;
    assign cpu_priority = {s_r.top_bit, s_r.sr[CAMS_SR_IPL_LO +: 3]};
    assign reg_rdata = s_r.rdata;

    // Assertions
    chk_div_len: assert property (@(posedge core_clk) disable iff (!nrst)
        (s_r.dv_st == DV_IDLE && s_nxt.dv_st == DV_ITER && !div_abort) ##1
        (!div_abort) [*8] ##1 (!div_abort) [*8] ##1 (!div_abort) [*2]
        |-> ##1 (res.wr_pair && res.idx == 4'h0))
        else $error("divide write-back not at expected cycle");
    chk_div_regs: assert property (@(posedge core_clk) disable iff (!nrst)
        (s_r.dv_st == DV_DONE && !div_abort) |=> (res.idx == 4'h0 && res.wr_pair))
        else $error("divide result not to register zero pair");
    chk_top_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        (!ipl_raise && !$past(ipl_raise) && $fell(s_r.top_bit)) |-> $past(reg_wr))
        else $error("priority top bit cleared without write");
    chk_top_set: assert property (@(posedge core_clk) disable iff (!nrst)
        ipl_raise |=> cpu_priority[3])
        else $error("priority top bit not set");
    chk_ctrl_read: assert property (@(posedge core_clk) disable iff (!nrst)
        (reg_rd && reg_addr == CAMS_ADDR_CTRL) |=> (reg_rdata[15:4] == 12'h000 &&
        reg_rdata[2] == 1'b1 && reg_rdata[1:0] == 2'b00))
        else $error("control word read value wrong");
    chk_shift_reg: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && !busy && req.op inside {OP_ASR, OP_SL, OP_LSR}) |=> !res.wr_mem)
        else $error("shift result sent to memory");
    chk_zero_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && !busy && req.op == OP_AND && !req.byte_mode) |=>
        (alu_status_word[CAMS_SR_Z] == (res.lo == 16'h0000)))
        else $error("zero flag mismatch");
    chk_sub_carry: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && !busy && req.op == OP_SUB && !req.byte_mode && req.opa >= req.opb)
        |=> alu_status_word[CAMS_SR_C])
        else $error("borrow flag wrong");
    chk_busy_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (s_r.dv_st == DV_ITER) |-> busy)
        else $error("busy low during divide");
    cov_div: cover property (@(posedge core_clk) disable iff (!nrst) s_r.dv_st == DV_DONE);
    cov_abort: cover property (@(posedge core_clk) disable iff (!nrst)
        div_abort && s_r.dv_st == DV_ITER);
    cov_mul: cover property (@(posedge core_clk) disable iff (!nrst)
        req.valid && req.op == OP_MUL && req.mul_mode == MUL_US);
    cov_byte: cover property (@(posedge core_clk) disable iff (!nrst)
        req.valid && req.op == OP_ADD && req.byte_mode);

endmodule

// ===== tb/cams_regfile_model.sv
/*
 * Behavioural working register file and data memory write counter.
 * Assumes result writes arrive as one-cycle pulses on the res carrier.
 */
`timescale 1ns/10ps

module cams_regfile_model
    import cams_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Result writes from the datapath
    input wire cams_res_t res,
    // Count of data memory writes
    output logic [7:0] mem_wr_cnt
);
    logic [15:0] wreg [16];

    // Pair writes land the upper half in the odd neighbour, as the decoder expects
    always_ff @(posedge core_clk) begin
        if (res.wr_pair) begin
            wreg[res.idx] <= res.lo;
            wreg[res.idx + 4'h1] <= res.hi;
        end else if (res.wr_reg) begin
            wreg[res.idx] <= res.lo;
        end
        if (!nrst) begin
            mem_wr_cnt <= 8'h00;
        end else if (res.wr_mem) begin
            mem_wr_cnt <= mem_wr_cnt + 8'h01;
        end
    end
endmodule

// ===== tb/cams_tb_top.sv
/*
 * Self-checking bench for the arithmetic datapath, one task per scenario.
 * Assumes the package constants and the hand-over timing of the design.
 */
`timescale 1ns/10ps

module cpu_alu_mul_div_shift_tb_top import cams_pkg::*;;
    // Stimulus and observed outputs
    logic core_clk, nrst, div_abort, ipl_raise, reg_wr, reg_rd, busy;
    logic [3:0] reg_addr, cpu_priority;
    logic [15:0] reg_wdata, alu_status_word, reg_rdata;
    logic [7:0] mem_wr_cnt;
    cams_req_t req;
    cams_res_t res;
    int n_fail = 0;
    int check_count = 0;

    cams_datapath dut_u (.core_clk, .nrst, .req, .div_abort, .ipl_raise, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .res, .busy, .alu_status_word, .cpu_priority,
        .reg_rdata);
    cams_regfile_model pm_u (.core_clk, .nrst, .res, .mem_wr_cnt);

    // Clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Issue one op and count cycles to its result pulse, bounded so a hang ends
    task automatic run_op(input cams_req_t r, output int n, output logic b1);
        @(posedge core_clk);
        req <= r;
        @(posedge core_clk);
        req <= '0;
        #1;
        n = 1;
        b1 = busy;
        while ((res.wr_reg | res.wr_mem | res.wr_pair) !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Reference add or subtract; flags placed at their status word positions
    function automatic logic [31:0] addsub(logic [15:0] a, logic [15:0] b, logic sb, logic bm);
        logic [15:0] nb;
        logic [16:0] s;
        logic [8:0] lb;
        logic [4:0] d4;
        logic c, dc, ov, z, n;
        nb = sb ? ~b : b;
        s = {1'b0, a} + {1'b0, nb} + 17'(sb);
        lb = {1'b0, a[7:0]} + {1'b0, nb[7:0]} + 9'(sb);
        d4 = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + 5'(sb);
        c = bm ? lb[8] : s[16];
        dc = bm ? d4[4] : lb[8];
        n = bm ? s[7] : s[15];
        z = bm ? (s[7:0] == 8'h00) : (s[15:0] == 16'h0000);
        ov = bm ? (a[7] == nb[7] && s[7] != a[7]) : (a[15] == nb[15] && s[15] != a[15]);
        return {7'h00, dc, 4'h0, n, ov, z, c, s[15:0]};
    endfunction

    task automatic t_reset();
        nrst <= 1'b0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #1;
        check({busy, alu_status_word, cpu_priority, res.wr_reg, res.wr_mem, res.wr_pair},
            0);
    endtask

    // Control and status words through the register port
    task automatic t_ctrl();
        logic [15:0] d;
        reg_read(CAMS_ADDR_CTRL, d);
        check(d, 32'h0004);
        reg_write(CAMS_ADDR_CTRL, 16'hFFFF);
        reg_read(CAMS_ADDR_CTRL, d);
        check(d, 32'h0004);
        @(posedge core_clk);
        ipl_raise <= 1'b1;
        @(posedge core_clk);
        ipl_raise <= 1'b0;
        reg_read(CAMS_ADDR_CTRL, d);
        check(d, 32'h000C);
        reg_write(CAMS_ADDR_STAT, 16'h00A0);
        check(cpu_priority, 32'hD);
        reg_write(CAMS_ADDR_CTRL, 16'h0000);
        check(cpu_priority, 32'h5);
        reg_read(4'hF, d);
        check(d, 32'h0000);
    endtask

    // Word and byte add and subtract, with carry and overflow corners
    task automatic t_addsub();
        logic [15:0] av [6] = '{16'h7FFF, 16'hFFFF, 16'h0005, 16'h0003, 16'h12FF, 16'h0080};
        logic [15:0] bv [6] = '{16'h0001, 16'h0001, 16'h0003, 16'h0005, 16'h0001, 16'h0001};
        logic [5:0] sv = 6'b101100;
        logic [5:0] bmv = 6'b110000;
        cams_req_t r;
        logic [31:0] e;
        logic b1;
        int n;
        for (int i = 0; i < 6; i++) begin
            r = '0;
            r.valid = 1'b1;
            r.op = sv[i] ? OP_SUB : OP_ADD;
            r.byte_mode = bmv[i];
            r.dst_mem = i[0];
            r.opa = av[i];
            r.opb = bv[i];
            r.mem_a = 16'hAB00;
            run_op(r, n, b1);
            e = addsub(av[i], bv[i], sv[i], bmv[i]);
            check(32'(n), 1);
            check({res.wr_mem, res.wr_reg}, {i[0], ~i[0]});
            check(res.lo, bmv[i] ? {8'hAB, e[7:0]} : e[15:0]);
            check(alu_status_word & 16'h010F, e[31:16]);
        end
    endtask

    // Logic ops, then each shift at 15 places and at one place
    task automatic t_logic_shift();
        cams_op_t opv [6] = '{OP_AND, OP_IOR, OP_XOR, OP_ASR, OP_SL, OP_LSR};
        logic [15:0] ev [3] = '{16'hF000, 16'hFFF0, 16'h0FF0};
        cams_req_t r;
        logic [15:0] e;
        logic [3:0] sh;
        logic b1;
        int n;
        for (int i = 0; i < 9; i++) begin
            sh = (i < 6) ? 4'hF : 4'h1;
            r = '0;
            r.valid = 1'b1;
            r.op = opv[(i < 3) ? i : 3 + i % 3];
            r.dst_mem = 1'b1;
            r.shamt = sh;
            r.opa = (i < 3) ? 16'hF0F0 : 16'h8001;
            r.opb = 16'hFF00;
            e = (i % 3 == 0) ? 16'($signed(r.opa) >>> sh) :
                (i % 3 == 1) ? r.opa << sh : r.opa >> sh;
            run_op(r, n, b1);
            check(res.lo, (i < 3) ? ev[i] : e);
            if (i > 2) begin
                check({res.wr_mem, res.wr_reg, 8'(n)}, {2'b01, 8'h01});
            end
        end
    endtask

    // Every multiplier form, with sign corners
    task automatic t_mul();
        cams_mul_t mv [6] = '{MUL_SS, MUL_UU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_BB};
        logic [15:0] av [6] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h12FF};
        logic [15:0] bv [6] = '{16'h0002, 16'h0002, 16'hFFFF, 16'h0000, 16'h0000, 16'h34FF};
        logic [31:0] ev [6] = '{32'hFFFFFFFE, 32'h0001FFFE, 32'hFFFF0001, 32'hFFFFFFE1,
            32'h001EFFE1, 32'h0000FE01};
        cams_req_t r;
        logic b1;
        int n;
        for (int i = 0; i < 6; i++) begin
            r = '0;
            r.valid = 1'b1;
            r.op = OP_MUL;
            r.mul_mode = mv[i];
            r.lit = 5'h1F;
            r.opa = av[i];
            r.opb = bv[i];
            run_op(r, n, b1);
            check({res.hi, res.lo}, ev[i]);
            check(res.wr_pair, 1'b1);
        end
    endtask

    // Both dividend sizes, signed and unsigned; results land in registers zero and one
    task automatic t_div();
        logic [3:0] mv [4] = '{4'b0100, 4'b1000, 4'b1100, 4'b0000};
        logic [15:0] hv [4] = '{16'h0001, 16'h0000, 16'hFFFF, 16'h1234};
        logic [15:0] lv [4] = '{16'h0000, 16'hFFF9, 16'hFFF9, 16'hFFFF};
        logic [15:0] dv [4] = '{16'h0003, 16'h0002, 16'h0002, 16'h0010};
        logic [31:0] ev [4] = '{32'h00015555, 32'hFFFFFFFD, 32'hFFFFFFFD, 32'h000F0FFF};
        logic [15:0] d;
        cams_req_t r;
        logic b1;
        int n;
        for (int i = 0; i < 4; i++) begin
            r = '0;
            r.valid = 1'b1;
            r.op = OP_DIV;
            r.div_signed = mv[i][3];
            r.div_long = mv[i][2];
            r.div_hi = hv[i];
            r.opa = lv[i];
            r.opb = dv[i];
            r.dst_idx = 4'h7;
            run_op(r, n, b1);
            check(32'(n), 19);
            check({b1, busy, res.idx}, 6'h20);
            @(posedge core_clk);
            #1;
            check({pm_u.wreg[1], pm_u.wreg[0]}, ev[i]);
            reg_read(CAMS_ADDR_DSTAT, d);
            check(d, 32'(CAMS_DIV_CYCLES));
        end
    endtask

    // Abandoned divide writes nothing; a request while busy is ignored
    task automatic t_abort();
        cams_req_t r;
        int hits;
        r = '0;
        r.valid = 1'b1;
        r.op = OP_DIV;
        r.opa = 16'h0064;
        r.opb = 16'h0007;
        @(posedge core_clk);
        req <= r;
        @(posedge core_clk);
        req <= '0;
        repeat (3) @(posedge core_clk);
        r.op = OP_ADD;
        req <= r;
        @(posedge core_clk);
        req <= '0;
        div_abort <= 1'b1;
        #1;
        // Divide still running, and the add offered meanwhile was refused
        check({busy, res.wr_reg}, 2'b10);
        @(posedge core_clk);
        div_abort <= 1'b0;
        hits = 0;
        repeat (30) begin
            @(posedge core_clk);
            #1;
            hits += int'(res.wr_pair | res.wr_reg);
        end
        check(32'(hits), 0);
        check(busy, 1'b0);
    endtask

    // Main sequence
    initial begin
        {nrst, div_abort, ipl_raise, reg_wr, reg_rd} = 5'b00000;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        req = '0;
        t_reset();
        t_ctrl();
        t_addsub();
        t_logic_shift();
        t_mul();
        t_div();
        t_abort();
        check(mem_wr_cnt, 8'h06);
        t_reset();
        check(mem_wr_cnt, 8'h00);
        finish_test();
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end
endmodule
